// File: dv/conv_core_model.sv
/*
  Behavioural converter core: answers each start pulse with one set of samples.
  Assumes the controller never starts a new sample before the last one is done.
*/
module conv_core_model
  import avg_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Handshake with the controller
  input  wire logic                    start_i,
  input  wire logic [9:0]              latency_i,
  output logic                         done_o,
  output avg_ctrl_pkg::chan_set_t      data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  int cnt;

  // ==========================================================
  // Sample engine
  // Outside a done pulse and reset (which clears them) the data lines flip every cycle, so stale values never pass as valid.
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      cnt = 0;
      data_o <= '0;
    end else if (start_i) begin
      cnt = latency_i;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        done_o <= 1'b1;
        for (int c = 0; c < NUM_CHAN; c++) begin
          data_o[c] <= 16'($urandom);
        end
      end
    end
  end
endmodule : conv_core_model

// File: dv/oversampling_average_control_bench.sv
/*
  Self-checking bench for the oversampling and averaging controller.
  Assumes the converter core model conv_core_model on the sample handshake.
*/
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module oversampling_average_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import avg_ctrl_pkg::*;

  localparam int RUN_CYC = 90000;

  logic       clk_sys_i, rst_i, trig, rp, busy, start, done, valid;
  logic [2:0] pins;
  logic [9:0] lat;
  logic [7:0] rdata, d;
  reg_req_t   req;
  chan_set_t  data, res, exp_res;
  int         err_count, compares, starts, valids, nobusy, cyc, last_st, gap;
  longint     sums [NUM_CHAN];
  int         fh [16] = '{1600, 1506, 1422, 1347, 1280, 1219, 1164, 1113,
                          1066, 1024, 985, 948, 914, 883, 853, 826};

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  oversampling_average_control i_oversampling_average_control (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .reg_req_i          (req),
    .reg_rdata_o        (rdata),
    .convert_trigger_i  (trig),
    .ratio_select_pins_i(pins),
    .reset_pin_i        (rp),
    .busy_o             (busy),
    .sample_start_o     (start),
    .sample_done_i      (done),
    .sample_data_i      (data),
    .result_o           (res),
    .result_valid_o     (valid)
  );

  conv_core_model i_conv_core_model (
    .clk_sys_i(clk_sys_i),
    .rst_i    (rst_i),
    .start_i  (start),
    .latency_i(lat),
    .done_o   (done),
    .data_o   (data)
  );

  // ==========================================================
  // Monitor
  always @(posedge clk_sys_i) begin
    cyc++;
    if (start) begin
      starts++;
      gap = cyc - last_st;
      last_st = cyc;
    end
    if (done) begin
      nobusy += (busy !== 1'b1);
      foreach (sums[c]) sums[c] += $signed(data[c]);
    end
    if (valid === 1'b1) valids++;
  end

  // ==========================================================
  // Expectations and tasks
  function automatic logic [15:0] exp_mean(input longint s, input int sh);
    return 16'(s >>> sh);
  endfunction : exp_mean

  function automatic int exp_period(input int p);
    return 500000 / fh[p];
  endfunction : exp_period

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge clk_sys_i);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys_i);
    req.rd   <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys_i);
  endtask : rd

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask : rdchk

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask : end_test

  // One averaged result; with internal timing, pins take their next code while busy is high.
  task automatic conv(input int n, input bit ext, input int sh, input logic [2:0] nxt);
    int k;
    starts = 0;
    valids = 0;
    nobusy = 0;
    foreach (sums[c]) sums[c] = 0;
    if (ext) begin
      repeat (n) begin
        k = 4 + $urandom_range(3);
        @(posedge clk_sys_i) trig <= 1'b1;
        repeat (k) @(posedge clk_sys_i);
        trig <= 1'b0;
        repeat (k) @(posedge clk_sys_i);
      end
    end else begin
      @(posedge clk_sys_i) trig <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      pins <= nxt;
      #1;
      `CHK(busy, 1'b1)
      `CHK(res, exp_res)
      repeat (20) @(posedge clk_sys_i);
      trig <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      if (n > 1) trig <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      trig <= 1'b0;
    end
    for (k = 0; k < 1000 * n + 2000 && valids == 0; k++) @(posedge clk_sys_i);
    if (!ext) repeat (350) @(posedge clk_sys_i);
    #1;
    `CHK(starts, n)
    `CHK(valids, 1)
    if (!ext) `CHK(nobusy, 0)
    for (k = 0; k < NUM_CHAN; k++) begin
      exp_res[k] = exp_mean(sums[k], sh);
      `CHK(res[k], exp_res[k])
    end
  endtask : conv

  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (RUN_CYC) @(posedge clk_sys_i);
    err_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Test sequence
  initial begin
    void'($urandom(32'h7b24_13cd));
    rst_i = 1'b1;
    trig  = 1'b0;
    rp    = 1'b0;
    pins  = 3'h0;
    lat   = 10'd4;
    req   = '0;
    exp_res = '0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rdchk(ADDR_CONFIG, 8'h00);
    rdchk(ADDR_AVG_SETUP, 8'h00);
    wr(6'h3f, 8'hff);
    rdchk(6'h3f, 8'h00);
    end_test("registers");
    for (int i = 0; i < 7; i++) begin
      lat <= (i == 2) ? 10'd400 : 10'(1 + $urandom_range(19));
      conv(1 << i, 1'b0, i, (i == 6) ? 3'h6 : 3'(i + 1));
    end
    end_test("pin ratios");
    wr(ADDR_AVG_SETUP, 8'h35);
    lat <= 10'd5;
    valids = 0;
    @(posedge clk_sys_i) trig <= 1'b1;
    repeat (500) @(posedge clk_sys_i);
    rp <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rp   <= 1'b0;
    trig <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(busy, 1'b0)
    `CHK(res, chan_set_t'(0))
    `CHK(valids, 0)
    exp_res = '0;
    rdchk(ADDR_AVG_SETUP, 8'h35);
    rp <= 1'b1;
    repeat (600) @(posedge clk_sys_i);
    rp <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rdchk(ADDR_AVG_SETUP, 8'h00);
    end_test("reset pin");
    pins  <= 3'h7;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h40)
    for (int p = 0; p < 16; p++) begin
      lat <= 10'(1 + $urandom_range(19));
      wr(ADDR_AVG_SETUP, {4'(p), 4'h1});
      conv(2, 1'b0, 1, 3'h7);
      `CHK(gap, exp_period(p))
    end
    rdchk(ADDR_AVG_SETUP, 8'hf1);
    end_test("padding");
    lat <= 10'd2;
    wr(ADDR_CONFIG, 8'h20);
    wr(ADDR_AVG_SETUP, 8'h0c);
    rdchk(ADDR_STATUS, 8'h68);
    wr(ADDR_AVG_SETUP, 8'h08);
    conv(256, 1'b1, 8, 3'h7);
    wr(ADDR_AVG_SETUP, 8'h07);
    @(posedge clk_sys_i) trig <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    trig <= 1'b0;
    rp   <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rp <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(busy, 1'b0)
    conv(128, 1'b1, 7, 3'h7);
    end_test("external clock");
    tally_and_finish();
  end
endmodule : oversampling_average_control_bench

// File: pkg/avg_ctrl_pkg.sv
/*
  Shared constants and types for the oversampling and averaging controller.
  Assumes a 250 MHz system clock and a plain register port with byte data.
*/
package avg_ctrl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int RST_MIN_NS          = 55;
  localparam int RST_PARTIAL_MAX_NS  = 2000;
  localparam int RST_FULL_MIN_NS     = 3000;
  localparam int RST_MIN_CYC         = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PARTIAL_MAX_CYC = RST_PARTIAL_MAX_NS / CLK_PERIOD_NS;
  localparam int RST_FULL_MIN_CYC    = (RST_FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W           = 12;
  // Cycles per sample period for a clock given in units of 0.5 kHz.
  localparam int NS_PER_HALF_KHZ     = 2000000;
  localparam int CYC_PER_HALF_KHZ    = NS_PER_HALF_KHZ / CLK_PERIOD_NS;
  localparam int TIMER_W             = 10;

  // ==========================================================
  // Datapath
  localparam int NUM_CHAN  = 8;
  localparam int SAMPLE_W  = 16;
  localparam int MAX_SHIFT = 8;
  localparam int ACC_W     = SAMPLE_W + MAX_SHIFT;
  localparam int SHIFT_W   = 4;
  localparam int COUNT_W   = 9;

  // ==========================================================
  // Registers
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam logic [5:0]  ADDR_CONFIG     = 6'h02;
  localparam logic [5:0]  ADDR_AVG_SETUP  = 6'h08;
  localparam logic [5:0]  ADDR_STATUS     = 6'h30;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [7:0]  AVG_SETUP_RESET = 8'h00;
  localparam int          CFG_EXT_CLK_BIT = 5;
  localparam int          PAD_LSB         = 4;
  localparam int          STAT_BUSY_BIT   = 7;
  localparam int          STAT_SW_BIT     = 6;
  localparam int          STAT_EXT_BIT    = 5;
  localparam logic [2:0]  PINS_SW_CODE    = 3'h7;
  localparam logic [3:0]  SW_MAX_CODE     = 4'h8;
  localparam logic [3:0]  PAD_NONE        = 4'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef logic [NUM_CHAN-1:0][SAMPLE_W-1:0] chan_set_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_SPACE, ST_EXT_WAIT} state_t;

  // ==========================================================
  // Padding code to sample period in clock cycles.
  function automatic logic [TIMER_W-1:0] pad_period(input logic [3:0] code);
    int f;
    unique case (code)
      4'h0: f = 1600;
      4'h1: f = 1506;
      4'h2: f = 1422;
      4'h3: f = 1347;
      4'h4: f = 1280;
      4'h5: f = 1219;
      4'h6: f = 1164;
      4'h7: f = 1113;
      4'h8: f = 1066;
      4'h9: f = 1024;
      4'hA: f = 985;
      4'hB: f = 948;
      4'hC: f = 914;
      4'hD: f = 883;
      4'hE: f = 853;
      4'hF: f = 826;
    endcase
    return TIMER_W'(CYC_PER_HALF_KHZ / f);
  endfunction : pad_period

endpackage : avg_ctrl_pkg

// File: rtl/avg_accumulator.sv
/*
  Per-channel sum of samples and shift-based mean.
  Assumes the caller marks the first sample of each average and aborts on reset.
*/
module avg_accumulator #(
  parameter int NUM_CHAN = 8,
  parameter int SAMPLE_W = 16,
  parameter int ACC_W    = 24,
  parameter int SHIFT_W  = 4
) (
  // Clock and reset
  input  wire logic                                clk_sys_i,
  input  wire logic                                rst_i,
  // Control
  input  wire logic                                abort_i,
  input  wire logic                                add_i,
  input  wire logic                                first_i,
  input  wire logic [SHIFT_W-1:0]                  shift_i,
  // Data
  input  wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0]   sample_i,
  output logic      [NUM_CHAN-1:0][SAMPLE_W-1:0]   mean_o
);

  // ==========================================================
  // Full-precision sums, one per channel
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] base_w;
    logic signed [ACC_W-1:0] acc_d;
    logic signed [ACC_W-1:0] mean_w;

    assign base_w = first_i ? '0 : acc_q;
    assign acc_d  = base_w + ACC_W'(signed'(sample_i[ch]));
    assign mean_w = acc_d >>> shift_i;
    assign mean_o[ch] = mean_w[SAMPLE_W-1:0];

    always_ff @(posedge clk_sys_i) begin
      if (rst_i || abort_i) begin
        acc_q <= '0;
      end else if (add_i) begin
        acc_q <= acc_d;
      end
    end
  end

endmodule : avg_accumulator

// File: rtl/oversampling_average_control.sv
/*
  Oversampling and averaging sequencer for an eight-channel converter.
  Assumes synchronous pin inputs, a converter core that answers each
  sample_start_o pulse with one sample_done_i pulse, and a plain register port.
*/
// The plain strobed port was chosen for this implementation.
module oversampling_average_control
  import avg_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Register port
  input  wire avg_ctrl_pkg::reg_req_t reg_req_i,
  output logic [avg_ctrl_pkg::DATA_W-1:0] reg_rdata_o,
  // Device pins
  input  wire logic                  convert_trigger_i,
  input  wire logic [2:0]            ratio_select_pins_i,
  input  wire logic                  reset_pin_i,
  output logic                       busy_o,
  // Converter core
  output logic                       sample_start_o,
  input  wire logic                  sample_done_i,
  input  wire avg_ctrl_pkg::chan_set_t sample_data_i,
  // Results
  output avg_ctrl_pkg::chan_set_t    result_o,
  output logic                       result_valid_o
);
  import avg_ctrl_pkg::*;

  // ==========================================================
  // Reset pin pulse measurement
  logic                 rst_pin_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  logic                 rst_fall_w;
  logic                 partial_w;
  logic                 full_w;

  assign rst_fall_w = rst_pin_q && !reset_pin_i;
  assign partial_w  = rst_fall_w && (rst_cnt_q >= RST_CNT_W'(RST_MIN_CYC))
                      && (rst_cnt_q <= RST_CNT_W'(RST_PARTIAL_MAX_CYC));
  assign full_w     = rst_fall_w && (rst_cnt_q > RST_CNT_W'(RST_PARTIAL_MAX_CYC));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_pin_q <= 1'b0;
      rst_cnt_q <= '0;
    end else begin
      rst_pin_q <= reset_pin_i;
      if (!reset_pin_i) begin
        rst_cnt_q <= '0;
      end else if (!(&rst_cnt_q)) begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  logic [DATA_W-1:0] config_q;
  logic [DATA_W-1:0] avg_setup_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] status_w;
  logic              wr_config_w;
  logic              wr_avg_w;
  logic              cfg_rst_w;

  assign cfg_rst_w   = rst_i || full_w;
  assign wr_config_w = reg_req_i.wr && (reg_req_i.addr == ADDR_CONFIG);
  assign wr_avg_w    = reg_req_i.wr && (reg_req_i.addr == ADDR_AVG_SETUP);

  always_ff @(posedge clk_sys_i) begin
    if (cfg_rst_w) begin
      config_q    <= CONFIG_RESET;
      avg_setup_q <= AVG_SETUP_RESET;
    end else begin
      if (wr_config_w) begin
        config_q <= reg_req_i.wdata;
      end
      if (wr_avg_w) begin
        avg_setup_q <= reg_req_i.wdata;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        ADDR_CONFIG:    rdata_d = config_q;
        ADDR_AVG_SETUP: rdata_d = avg_setup_q;
        ADDR_STATUS:    rdata_d = status_w;
        default:        rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // Mode and ratio selection
  logic               init_q;
  logic [2:0]         pins_q;
  logic               sw_mode_w;
  logic [3:0]         sw_code_w;
  logic [SHIFT_W-1:0] shift_w;
  logic               ext_mode_w;
  logic [3:0]         pad_w;
  logic               busy_fall_w;
  state_t             state_q;
  state_t             state_d;

  assign sw_mode_w  = (pins_q == PINS_SW_CODE);
  assign sw_code_w  = (avg_setup_q[3:0] > SW_MAX_CODE) ? SW_MAX_CODE : avg_setup_q[3:0];
  assign shift_w    = sw_mode_w ? sw_code_w : {1'b0, pins_q};
  assign ext_mode_w = sw_mode_w && (shift_w != '0) && config_q[CFG_EXT_CLK_BIT];
  assign pad_w      = sw_mode_w ? avg_setup_q[PAD_LSB +: 4] : PAD_NONE;
  assign busy_fall_w = (state_q != ST_IDLE) && (state_d == ST_IDLE);

  // Pins are caught once after reset release, then at each busy fall and at the end of a full reset pin pulse.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_q <= 1'b1;
      pins_q <= '0;
    end else begin
      init_q <= 1'b0;
      if (init_q || busy_fall_w || full_w) begin
        pins_q <= ratio_select_pins_i;
      end
    end
  end

  // ==========================================================
  // Sample sequencer
  logic                trig_q;
  logic                trig_rise_w;
  logic [SHIFT_W-1:0]  run_shift_q;
  logic                run_ext_q;
  logic [TIMER_W-1:0]  run_period_q;
  logic [TIMER_W-1:0]  timer_q;
  logic [COUNT_W-1:0]  count_q;
  logic                first_q;
  logic                start_q;
  logic                start_d;
  logic                last_w;
  logic                abort_w;
  logic                valid_q;
  chan_set_t           result_q;
  chan_set_t           mean_w;

  assign trig_rise_w = convert_trigger_i && !trig_q;
  assign abort_w     = partial_w || full_w;
  assign last_w      = (count_q + 1'b1) == (COUNT_W'(1) << run_shift_q);

  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (trig_rise_w) begin
          state_d = ST_CONVERT;
          start_d = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (sample_done_i) begin
          if (last_w) begin
            state_d = ST_IDLE;
          end else if (run_ext_q) begin
            state_d = ST_EXT_WAIT;
          end else begin
            state_d = ST_SPACE;
          end
        end
      end
      ST_SPACE: begin
        if (timer_q == '0) begin
          state_d = ST_CONVERT;
          start_d = 1'b1;
        end
      end
      ST_EXT_WAIT: begin
        if (trig_rise_w) begin
          state_d = ST_CONVERT;
          start_d = 1'b1;
        end
      end
    endcase
    if (abort_w) begin
      state_d = ST_IDLE;
      start_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      trig_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      trig_q  <= convert_trigger_i;
      start_q <= start_d;
    end
  end

  // Ratio and mode are frozen for the whole result; the spacing timer reloads from the live padding code.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_shift_q  <= '0;
      run_ext_q    <= 1'b0;
      run_period_q <= '0;
      count_q      <= '0;
      first_q      <= 1'b0;
    end else if (state_q == ST_IDLE && trig_rise_w) begin
      run_shift_q  <= shift_w;
      run_ext_q    <= ext_mode_w;
      run_period_q <= pad_period(pad_w);
      count_q      <= '0;
      first_q      <= 1'b1;
    end else if (state_q == ST_CONVERT && sample_done_i) begin
      count_q <= count_q + 1'b1;
      first_q <= 1'b0;
    end
  end

  // Spacing timer restarts at every sample instant.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_q <= '0;
    end else if (start_d) begin
      timer_q <= pad_period(pad_w) - 1'b1;
    end else if (timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  avg_accumulator #(
    .NUM_CHAN (NUM_CHAN),
    .SAMPLE_W (SAMPLE_W),
    .ACC_W    (ACC_W),
    .SHIFT_W  (SHIFT_W)
  ) u_accum (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .abort_i   (abort_w),
    .add_i     (state_q == ST_CONVERT && sample_done_i),
    .first_i   (first_q),
    .shift_i   (run_shift_q),
    .sample_i  (sample_data_i),
    .mean_o    (mean_w)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || abort_w) begin
      result_q <= '0;
      valid_q  <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (state_q == ST_CONVERT && sample_done_i && last_w) begin
        result_q <= mean_w;
        valid_q  <= 1'b1;
      end
    end
  end

  assign busy_o         = (state_q != ST_IDLE);
  assign sample_start_o = start_q;
  assign result_o       = result_q;
  assign result_valid_o = valid_q;

  assign status_w = DATA_W'({busy_o, sw_mode_w, ext_mode_w, 1'b0, shift_w});

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || abort_w);

  sequence s_trig_in_idle;
    (state_q == ST_IDLE) && trig_rise_w;
  endsequence

  sequence s_last_sample;
    (state_q == ST_CONVERT) && sample_done_i && last_w;
  endsequence

  a_first_sample_start: assert property (s_trig_in_idle |=> sample_start_o && busy_o)
    else $error("Trigger in idle did not start a sample.");

  a_busy_until_result: assert property (s_last_sample |=> result_valid_o && !busy_o)
    else $error("Busy did not end with the result.");

  a_idle_no_start: assert property (!busy_o && !trig_rise_w |=> !sample_start_o)
    else $error("Sample started while idle without trigger.");

  a_pins_latched: assert property ($fell(busy_o) |-> pins_q == $past(ratio_select_pins_i))
    else $error("Select pins not latched at busy fall.");

  a_sw_mode_pins: assert property (sw_mode_w |-> shift_w == sw_code_w && shift_w <= SW_MAX_CODE)
    else $error("Software ratio not taken from register.");

  a_hw_ratio_max: assert property (!sw_mode_w |-> shift_w < 4'h7)
    else $error("Hardware mode ratio above 64.");

  a_space_timing: assert property ((state_q == ST_SPACE) && (timer_q == '0) |=> sample_start_o)
    else $error("Internal sample not issued when timer expired.");

  a_ext_edge_sample: assert property ((state_q == ST_EXT_WAIT) && trig_rise_w |=> sample_start_o)
    else $error("External edge did not take a sample.");

  a_count_bound: assert property (busy_o |-> count_q < (COUNT_W'(1) << run_shift_q))
    else $error("Sample count exceeded ratio.");

  a_partial_abort: assert property (disable iff (rst_i) partial_w |=> !busy_o && result_o == '0)
    else $error("Partial reset did not abort averaging.");

endmodule : oversampling_average_control
